//--- core/ebsc_pkg.sv
// Purpose: constants shared by the external bus sdram configuration block
// Assumes: byte registers, one per 32-bit wishbone word (byte address = index * 4)
// Notes: codes follow the field tables of the control registers
package ebsc_pkg;
    // ************************************************************
    // register indexes
    // ************************************************************
    localparam logic [5:0] IDX_BUS_CTRL = 6'h00;
    localparam logic [5:0] IDX_GEOMETRY = 6'h01;
    localparam logic [5:0] IDX_REFRESH_LO = 6'h04;
    localparam logic [5:0] IDX_REFRESH_HI = 6'h05;
    localparam logic [5:0] IDX_INIT_LO = 6'h06;
    localparam logic [5:0] IDX_INIT_HI = 6'h07;
    localparam logic [5:0] IDX_CS_SETUP = 6'h0C;
    localparam logic [5:0] IDX_STATUS = 6'h0D;
    // ************************************************************
    // reset values and writable masks
    // ************************************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] MASK_GEOMETRY = 8'h0F;
    localparam logic [7:0] MASK_REFRESH_HI = 8'h03;
    localparam logic [7:0] MASK_INIT_HI = 8'h3F;
    localparam logic [7:0] MASK_CS_SETUP = 8'h03;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int POS_WIDTH = 6;
    localparam int POS_LPC = 4;
    localparam int POS_SRAM = 2;
    localparam int POS_PORTS = 0;
    localparam int POS_CAS = 3;
    localparam int POS_ROW = 2;
    localparam int POS_COL = 0;
    localparam int POS_CS3_SDRAM = 0;
    localparam int POS_COMBINED = 1;
    // ************************************************************
    // field codes
    // ************************************************************
    localparam logic [1:0] PORTS_OFF = 2'h0;
    localparam logic [1:0] PORTS_THREE = 2'h1;
    localparam logic [1:0] PORTS_FOUR = 2'h2;
    localparam logic [1:0] PORTS_TWO = 2'h3;
    localparam logic [1:0] WIDTH_FOUR = 2'h0;
    localparam logic [1:0] WIDTH_EIGHT = 2'h1;
    localparam logic [1:0] LPC_FIRST = 2'h0;
    localparam logic [1:0] LPC_BOTH = 2'h2;
    localparam logic [1:0] SRAM_FIRST = 2'h0;
    localparam logic [1:0] SRAM_SECOND = 2'h1;
    localparam logic [1:0] SRAM_BOTH = 2'h2;
    localparam logic [1:0] SRAM_NONE = 2'h3;
    // ************************************************************
    // counts
    // ************************************************************
    localparam logic [2:0] PENDING_MAX = 3'h4;
    localparam logic [3:0] ROW_BITS_BASE = 4'hB;
    localparam logic [3:0] COL_BITS_BASE = 4'h8;
    localparam logic [1:0] LATENCY_BASE = 2'h2;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_WAIT = 6'h02,
        ST_PRECH = 6'h04,
        ST_AREF = 6'h08,
        ST_LMODE = 6'h10,
        ST_READY = 6'h20
    } ebsc_state_type;
endpackage

//--- core/ebsc_core.sv
// Purpose: configuration registers, refresh scheduling and sdram start-up sequencing
// Assumes: classic wishbone slave on MCLK; peripheral double clock arrives as a pin
// Notes: all sequencing counts rising edges of the peripheral double clock
// What this block does
// - width code 00 four bits, 01 eight
// - eight-bit data only with four ports
// - low pin mode picks latch strobes used
// - sram mode picks address multiplexing scheme
// - second-strobe and unlatched modes need four ports
// - port count field enables two/three/four ports
// - latency bit gives two or three cycles
// - row bit gives eleven or twelve row bits
// - column code gives eight to eleven bits
// - ten-bit refresh period paces refresh commands
// - remember up to four refreshes while busy
// - fourteen-bit init delay; fields reset zero
// - unused upper register bits read zero
// - combined sram/sdram only with four ports
// - wait delay, precharge, refresh, load mode
// - chip select three sdram starts initialization
// - initialization cannot be interrupted by accesses
//
// Added by the designer: register access over Wishbone.
module ebsc_core
    import ebsc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic PERIPH_CLK2,
    input wire logic MEM_BUSY,
    output logic [2:0] PORT_COUNT,
    output logic SD_WIDE_BUS,
    output logic [1:0] READ_LATENCY,
    output logic [3:0] ROW_BITS,
    output logic [3:0] COL_BITS,
    output logic [1:0] SRAM_LATCH_USE,
    output logic [1:0] LPC_LATCH_USE,
    output logic SRAM_MODE_OK,
    output logic COMBINED_EN,
    output logic SD_PRECHARGE,
    output logic SD_AUTO_REFRESH,
    output logic SD_LOAD_MODE,
    output logic INIT_BUSY,
    output logic INIT_DONE,
    output logic [2:0] PENDING
);
    import ebsc_pkg::*;

    // ************************************************************
    // register bus
    // ************************************************************
    logic [7:0] ctrl_q, geom_q, ref_lo_q, ref_hi_q, init_lo_q, init_hi_q, cs_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [2:0] pend_q;
    ebsc_state_type st_q, st_d;

    wire [5:0] idx = WB_ADR_I[7:2];
    wire req = WB_CYC_I & WB_STB_I;
    // a write lands on the edge at which the master sees ack
    wire wr = req & WB_WE_I & WB_SEL_I[0] & ack_q;
    wire [7:0] wd = WB_DAT_I[7:0];
    wire [7:0] status_byte = {3'h0, pend_q, INIT_BUSY, INIT_DONE};
    logic [7:0] rd_byte;

    // read mux; unused high bits come back as zero
    always_comb begin
        unique case (idx)
            IDX_BUS_CTRL: rd_byte = ctrl_q;
            IDX_GEOMETRY: rd_byte = geom_q & MASK_GEOMETRY;
            IDX_REFRESH_LO: rd_byte = ref_lo_q;
            IDX_REFRESH_HI: rd_byte = ref_hi_q & MASK_REFRESH_HI;
            IDX_INIT_LO: rd_byte = init_lo_q;
            IDX_INIT_HI: rd_byte = init_hi_q & MASK_INIT_HI;
            IDX_CS_SETUP: rd_byte = cs_q & MASK_CS_SETUP;
            IDX_STATUS: rd_byte = status_byte;
            default: rd_byte = RST_BYTE;
        endcase
    end

    // one wait state, unmapped addresses still answer with zero
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            rdat_q <= {24'h00_0000, rd_byte};
        end
    end
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdat_q;

    // configuration storage, all zero after reset
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= RST_BYTE;
            geom_q <= RST_BYTE;
            ref_lo_q <= RST_BYTE;
            ref_hi_q <= RST_BYTE;
            init_lo_q <= RST_BYTE;
            init_hi_q <= RST_BYTE;
            cs_q <= RST_BYTE;
        end else if (wr) begin
            if (idx == IDX_BUS_CTRL) ctrl_q <= wd;
            if (idx == IDX_GEOMETRY) geom_q <= wd & MASK_GEOMETRY;
            if (idx == IDX_REFRESH_LO) ref_lo_q <= wd;
            if (idx == IDX_REFRESH_HI) ref_hi_q <= wd & MASK_REFRESH_HI;
            if (idx == IDX_INIT_LO) init_lo_q <= wd;
            if (idx == IDX_INIT_HI) init_hi_q <= wd & MASK_INIT_HI;
            if (idx == IDX_CS_SETUP) cs_q <= wd & MASK_CS_SETUP;
        end
    end

    // ************************************************************
    // field decode
    // ************************************************************
    wire [1:0] width_sel = ctrl_q[POS_WIDTH +: 2];
    wire [1:0] lpc_sel = ctrl_q[POS_LPC +: 2];
    wire [1:0] sram_sel = ctrl_q[POS_SRAM +: 2];
    wire [1:0] port_sel = ctrl_q[POS_PORTS +: 2];
    wire four_port = (port_sel == PORTS_FOUR);
    wire [9:0] period = {ref_hi_q[1:0], ref_lo_q};
    wire [13:0] init_dly = {init_hi_q[5:0], init_lo_q};
    // enabled ports; reserved codes of other fields are left undefined, mapped to off
    wire [2:0] ports_w = (port_sel == PORTS_THREE) ? 3'h3 :
                         (port_sel == PORTS_FOUR) ? 3'h4 :
                         (port_sel == PORTS_TWO) ? 3'h2 : 3'h0;
    wire wide_w = (width_sel == WIDTH_EIGHT) & four_port;
    // sram latch use: bit 0 first strobe, bit 1 second strobe
    wire [1:0] sram_latch_w = (sram_sel == SRAM_FIRST) ? 2'h1 :
                              (sram_sel == SRAM_SECOND) ? 2'h2 :
                              (sram_sel == SRAM_BOTH) ? 2'h3 : 2'h0;
    wire sram_ok_w = four_port | (sram_sel == SRAM_FIRST) | (sram_sel == SRAM_BOTH);
    wire [1:0] lpc_latch_w = (lpc_sel == LPC_FIRST) ? 2'h1 :
                             (lpc_sel == LPC_BOTH) ? 2'h3 : 2'h0;
    wire comb_w = cs_q[POS_COMBINED] & four_port;
    wire [1:0] lat_w = LATENCY_BASE + {1'b0, geom_q[POS_CAS]};
    wire [3:0] row_w = ROW_BITS_BASE + {3'h0, geom_q[POS_ROW]};
    wire [3:0] col_w = COL_BITS_BASE + {2'h0, geom_q[POS_COL +: 2]};

    // configuration outputs from flip-flops
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            PORT_COUNT <= 3'h0;
            SD_WIDE_BUS <= 1'b0;
            READ_LATENCY <= LATENCY_BASE;
            ROW_BITS <= ROW_BITS_BASE;
            COL_BITS <= COL_BITS_BASE;
            SRAM_LATCH_USE <= 2'h1;
            LPC_LATCH_USE <= 2'h1;
            SRAM_MODE_OK <= 1'b1;
            COMBINED_EN <= 1'b0;
        end else begin
            PORT_COUNT <= ports_w;
            SD_WIDE_BUS <= wide_w;
            READ_LATENCY <= lat_w;
            ROW_BITS <= row_w;
            COL_BITS <= col_w;
            SRAM_LATCH_USE <= sram_latch_w;
            LPC_LATCH_USE <= lpc_latch_w;
            SRAM_MODE_OK <= sram_ok_w;
            COMBINED_EN <= comb_w;
        end
    end

    // ************************************************************
    // peripheral double clock edge finder
    // ************************************************************
    logic pclk_s1_q, pclk_s2_q, pclk_s3_q;
    // first stage feeds only the second; edges are seen after two flops
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pclk_s1_q <= 1'b0;
            pclk_s2_q <= 1'b0;
            pclk_s3_q <= 1'b0;
        end else begin
            pclk_s1_q <= PERIPH_CLK2;
            pclk_s2_q <= pclk_s1_q;
            pclk_s3_q <= pclk_s2_q;
        end
    end
    wire tick = pclk_s2_q & ~pclk_s3_q;

    // ************************************************************
    // refresh timer and pending count
    // ************************************************************
    logic [9:0] ref_cnt_q;
    // a zero period means refresh is not configured
    wire due = tick & (period != 10'h000) & (ref_cnt_q >= period - 10'h001);
    wire enabled = (port_sel != PORTS_OFF) & cs_q[POS_CS3_SDRAM];
    // issue only when the bus is free and start-up is over
    wire issue = (pend_q != 3'h0) & ~MEM_BUSY & (st_q == ST_READY) & ~SD_AUTO_REFRESH;
    wire inc = due & (pend_q != PENDING_MAX);

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ref_cnt_q <= 10'h000;
        end else if (due | ~enabled) begin
            ref_cnt_q <= 10'h000;
        end else if (tick) begin
            ref_cnt_q <= ref_cnt_q + 10'h001;
        end
    end

    // an arrival in the same cycle as an issue is kept: net change zero, except at four pending where the arrival is dropped
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pend_q <= 3'h0;
        end else if (!enabled) begin
            pend_q <= 3'h0;
        end else if (inc & ~issue) begin
            pend_q <= pend_q + 3'h1;
        end else if (issue & ~inc) begin
            pend_q <= pend_q - 3'h1;
        end
    end
    assign PENDING = pend_q;

    // ************************************************************
    // start-up sequencer
    // ************************************************************
    logic [13:0] init_cnt_q;
    wire wait_done = tick & (init_cnt_q >= init_dly);

    // steps advance on peripheral clock edges; bus traffic cannot stop them
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: if (enabled) st_d = ST_WAIT;
            ST_WAIT: if (wait_done) st_d = ST_PRECH;
            ST_PRECH: if (tick) st_d = ST_AREF;
            ST_AREF: if (tick) st_d = ST_LMODE;
            ST_LMODE: if (tick) st_d = ST_READY;
            ST_READY: st_d = ST_READY;
            default: st_d = ST_IDLE;
        endcase
        // only software turning the interface off ends the sequence
        if (!enabled) st_d = ST_IDLE;
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= ST_IDLE;
            init_cnt_q <= 14'h0000;
        end else begin
            st_q <= st_d;
            if (st_q != ST_WAIT) init_cnt_q <= 14'h0000;
            else if (tick) init_cnt_q <= init_cnt_q + 14'h0001;
        end
    end

    // command pulses, one MCLK cycle each
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            SD_PRECHARGE <= 1'b0;
            SD_AUTO_REFRESH <= 1'b0;
            SD_LOAD_MODE <= 1'b0;
            INIT_BUSY <= 1'b0;
            INIT_DONE <= 1'b0;
        end else begin
            SD_PRECHARGE <= (st_q == ST_PRECH) & tick & enabled;
            SD_AUTO_REFRESH <= ((st_q == ST_AREF) & tick & enabled) | issue;
            SD_LOAD_MODE <= (st_q == ST_LMODE) & tick & enabled;
            INIT_BUSY <= (st_d != ST_IDLE) & (st_d != ST_READY);
            INIT_DONE <= (st_d == ST_READY);
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    a_pending_cap: assert property (pend_q <= PENDING_MAX)
        else $error("pending refresh count above four");
    a_issue_drops: assert property ((issue && !inc && enabled) |=> pend_q == $past(pend_q) - 3'h1)
        else $error("issued refresh did not lower pending count");
    a_due_sat: assert property ((due && pend_q == PENDING_MAX && !issue && enabled) |=> pend_q == PENDING_MAX)
        else $error("pending count did not saturate");
    // watch the pulse itself, so a broken issue term cannot hide behind its own definition
    a_issue_gate: assert property ((SD_AUTO_REFRESH && INIT_DONE) |-> !$past(MEM_BUSY) && $past(pend_q) != 3'h0)
        else $error("refresh issued while busy or not ready");
    a_wide_gate: assert property (SD_WIDE_BUS |-> $past(four_port) && $past(width_sel) == WIDTH_EIGHT)
        else $error("eight-bit bus without four ports");
    a_init_order: assert property ((st_q == ST_PRECH && tick && enabled) |=> SD_PRECHARGE && st_q == ST_AREF)
        else $error("precharge step out of order");
    a_busy_hold: assert property ((st_q == ST_AREF && enabled && MEM_BUSY) |=> st_q != ST_IDLE)
        else $error("start-up sequence interrupted");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held for two cycles");
    a_hi_zero: assert property ((WB_ACK_O && !WB_WE_I && idx == IDX_REFRESH_HI) |-> WB_DAT_O[31:2] == 30'h0)
        else $error("reserved refresh bits read nonzero");
    a_sram_gate: assert property (($past(port_sel) != PORTS_FOUR && ($past(sram_sel) == SRAM_SECOND || $past(sram_sel) == SRAM_NONE)) |-> !SRAM_MODE_OK)
        else $error("sram mode allowed without four ports");
endmodule

//--- testbench/ebsc_mem_model.sv
// Purpose: memory-side partner that watches sdram commands and makes bus traffic
// Assumes: commands are one-cycle pulses on mclk
// Notes: busy time is given per request, in mclk cycles
module ebsc_mem_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [12:0] hold,
    input wire logic prech,
    input wire logic aref,
    input wire logic lmode,
    output logic mem_busy,
    output logic init_seen,
    output logic seq_ok,
    output logic busy_hit,
    output logic [7:0] n_aref
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] busy_q;
    logic [1:0] step_q;
    assign mem_busy = (busy_q != 13'h0000);
    assign init_seen = (step_q == 2'h3);
    // another access holds the bus while the count runs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 13'h0000;
        end else if (start) begin
            busy_q <= hold;
        end else if (mem_busy) begin
            busy_q <= busy_q - 13'h0001;
        end
    end
    // a real part is lost unless precharge, refresh, load mode come in order
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            step_q <= 2'h0;
            seq_ok <= 1'b1;
            busy_hit <= 1'b0;
            n_aref <= 8'h00;
        end else begin
            if (prech) begin
                if (step_q == 2'h0) step_q <= 2'h1;
                else seq_ok <= 1'b0;
            end
            if (aref) begin
                if (step_q == 2'h1) step_q <= 2'h2;
                else if (step_q != 2'h3) seq_ok <= 1'b0;
                else n_aref <= n_aref + 8'h01;
            end
            if (lmode) begin
                if (step_q == 2'h2) step_q <= 2'h3;
                else seq_ok <= 1'b0;
            end
            // a refresh on top of a running access would corrupt it
            if (aref && mem_busy && init_seen) busy_hit <= 1'b1;
        end
    end
endmodule

//--- testbench/ebsc_core_tb.sv
// Purpose: self-checking bench for the external bus sdram configuration block
// Assumes: one byte register per wishbone word; peripheral double clock of 80 ns
// Notes: expectations come from the field tables, not from the design
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module ebsc_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ebsc_pkg::*;
    logic mclk = 0, pclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, start = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o;
    logic [12:0] hold = 13'h0000;
    logic ack, mem_busy, wide, sram_ok, comb, prech, aref, lmode, ibusy, idone, init_seen, seq_ok, busy_hit;
    logic [2:0] ports, pend;
    logic [1:0] lat, sram_use, lpc_use;
    logic [3:0] rows, cols;
    logic [7:0] n_aref, rd, snap;
    logic [2:0] pexp [4] = '{3'h0, 3'h3, 3'h4, 3'h2};
    logic [1:0] sexp [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    int mismatches = 0, n_tests = 0, cyc_n = 0, ticks = 0;
    ebsc_core i_ebsc_core (.MCLK(mclk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .PERIPH_CLK2(pclk), .MEM_BUSY(mem_busy), .PORT_COUNT(ports), .SD_WIDE_BUS(wide),
        .READ_LATENCY(lat), .ROW_BITS(rows), .COL_BITS(cols), .SRAM_LATCH_USE(sram_use),
        .LPC_LATCH_USE(lpc_use), .SRAM_MODE_OK(sram_ok), .COMBINED_EN(comb), .SD_PRECHARGE(prech),
        .SD_AUTO_REFRESH(aref), .SD_LOAD_MODE(lmode), .INIT_BUSY(ibusy), .INIT_DONE(idone),
        .PENDING(pend));
    ebsc_mem_model i_ebsc_mem_model (.mclk(mclk), .rst_n(rst_n), .start(start), .hold(hold),
        .prech(prech), .aref(aref), .lmode(lmode), .mem_busy(mem_busy), .init_seen(init_seen),
        .seq_ok(seq_ok), .busy_hit(busy_hit), .n_aref(n_aref));
    // ************************************************************
    // clocks and hang guard
    // ************************************************************
    always #2.5 mclk = ~mclk;
    // link clock offset so its edges keep a fixed 0.5 ns lag after an mclk edge
    initial begin
        #3;
        forever #40 pclk = ~pclk;
    end
    always @(posedge pclk) ticks++;
    always @(posedge mclk) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            mismatches++;
            summarize();
        end
    end
    // ************************************************************
    // bus tasks
    // ************************************************************
    task summarize;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // entered just after an edge; returns just after the edge following release
    task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic s0,
        output logic [7:0] q);
        int k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= {3'b000, s0};
        dat <= {24'h000000, d};
        do begin
            @(posedge mclk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = dat_o[7:0];
        `CHK(ack, 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d, 1'b1, rd);
    endtask
    task automatic rdchk(input logic [5:0] idx, input logic [7:0] e);
        xfer(1'b0, idx, 8'h00, 1'b1, rd);
        `CHK(rd, e);
    endtask
    // registered outputs follow one edge after the write lands; settle adds two more
    task automatic settle;
        repeat (2) @(posedge mclk);
    endtask
    task automatic kick(input logic [12:0] h);
        hold <= h;
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
    endtask
    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        int i, f, k, t0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        `CHK(lat, 2'h2);
        `CHK(rows, 4'hB);
        `CHK(cols, 4'h8);
        `CHK(ports, 3'h0);
        for (i = 0; i < 8; i++) rdchk(6'(i), 8'h00);
        $display("test reset done");
        wr(IDX_GEOMETRY, 8'hFF);
        rdchk(IDX_GEOMETRY, 8'h0F);
        wr(IDX_REFRESH_HI, 8'hFF);
        rdchk(IDX_REFRESH_HI, 8'h03);
        wr(IDX_INIT_HI, 8'hFF);
        rdchk(IDX_INIT_HI, 8'h3F);
        wr(IDX_REFRESH_LO, 8'hAB);
        rdchk(IDX_REFRESH_LO, 8'hAB);
        xfer(1'b1, IDX_INIT_LO, 8'h55, 1'b0, rd);
        rdchk(IDX_INIT_LO, 8'h00);
        wr(6'h3F, 8'h77);
        rdchk(6'h3F, 8'h00);
        wr(IDX_REFRESH_HI, 8'h00);
        wr(IDX_REFRESH_LO, 8'h00);
        $display("test masks done");
        for (i = 0; i < 16; i++) begin
            wr(IDX_GEOMETRY, 8'(i));
            settle();
            `CHK(lat, (i[3] ? 2'h3 : 2'h2));
            `CHK(rows, (i[2] ? 4'hC : 4'hB));
            `CHK(cols, 4'h8 + 4'(i[1:0]));
        end
        $display("test geometry done");
        for (i = 0; i < 4; i++) begin
            wr(IDX_BUS_CTRL, {6'b010000, 2'(i)});
            settle();
            `CHK(ports, pexp[i]);
            `CHK(wide, 1'(i == 2));
            for (f = 0; f < 2; f++) begin
                wr(IDX_BUS_CTRL, {2'b00, 1'(f), 1'b0, 2'(i), (f == 1 ? 2'h2 : 2'h1)});
                settle();
                `CHK(sram_use, sexp[i]);
                `CHK(sram_ok, 1'(f == 1 || i == 0 || i == 2));
                `CHK(lpc_use, (f == 1 ? 2'h3 : 2'h1));
            end
        end
        wr(IDX_CS_SETUP, 8'h02);
        for (f = 0; f < 2; f++) begin
            wr(IDX_BUS_CTRL, (f == 1 ? 8'h02 : 8'h01));
            settle();
            `CHK(comb, 1'(f == 1));
        end
        wr(IDX_CS_SETUP, 8'h00);
        $display("test modes done");
        wr(IDX_INIT_LO, 8'h03);
        wr(IDX_INIT_HI, 8'h01);
        // other traffic stays busy through every start-up step
        kick(13'd4500);
        t0 = ticks;
        wr(IDX_CS_SETUP, 8'h01);
        settle();
        `CHK(ibusy, 1'b1);
        for (k = 0; k < 6000 && idone !== 1'b1; k++) @(posedge mclk);
        // one more edge so the model has taken the load mode pulse
        @(posedge mclk);
        `CHK(idone, 1'b1);
        `CHK(seq_ok & init_seen, 1'b1);
        `CHK(1'(ticks - t0 >= 261 && ticks - t0 <= 266), 1'b1);
        `CHK(ibusy, 1'b0);
        rdchk(IDX_STATUS, 8'h01);
        $display("test startup done");
        wr(IDX_REFRESH_LO, 8'h04);
        kick(13'd450);
        repeat (420) @(posedge mclk);
        `CHK(pend, 3'h4);
        snap = n_aref;
        repeat (60) @(posedge mclk);
        `CHK(1'(8'(n_aref - snap) >= 8'd4 && 8'(n_aref - snap) <= 8'd5), 1'b1);
        `CHK(busy_hit, 1'b0);
        snap = n_aref;
        repeat (640) @(posedge mclk);
        `CHK(1'(8'(n_aref - snap) >= 8'd9 && 8'(n_aref - snap) <= 8'd11), 1'b1);
        $display("test refresh done");
        summarize();
    end
endmodule
